// *** core/uhb_host_bus_control.sv ***
/*
 * USB host-mode control and live line-status logic behind an APB port.
 * Assumes D+/D- receiver levels arrive asynchronously and a USB engine
 * raises the token request and consumes the line-drive controls.
 */
// Behaviour
// - Idle flag follows J-state, speed dependent polarity.
// - SE0 status high while both lines low.
// - Token busy bit reflects token in progress.
// - Bus reset bit drives reset signalling; software times.
// - Host enable switches on both line pull-downs.
// - Resume bit drives resume signalling; software times.
// - Rewind bit forces ping-pong pointers even.
// - Frame enable, with host enable set, sends start-of-frame every millisecond unless reset or resume is driven or a token is in progress at the frame tick.
`timescale 1ns/1ns
module uhb_host_bus_control #(
	parameter int FRAME_PERIOD = uhb_pkg::FRAME_CYCLES,
	parameter int TOKEN_CYCLES = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dPlusIn,
	input wire logic dMinusIn,
	input wire logic lowSpeed,
	input wire logic tokenRequest,
	output logic busResetDrive,
	output logic resumeDrive,
	output logic pullDownEnable,
	output logic hostRoleEnable,
	output logic bufferPointerRewind,
	output logic sofStart,
	output logic tokenInProgress
);
	logic [5:0] control;
	logic dPlus;
	logic dMinus;
	logic lineIdleStateFlag;
	logic lineSe0;
	logic [31:0] frameCount;
	logic [31:0] tokenCount;
	uhb_pkg::uhb_state_e state;
	uhb_pkg::uhb_state_e next_state;

	uhb_pin_sync syncPlus (
		.ref_clk(ref_clk),
		.srst(srst),
		.pinIn(dPlusIn),
		.level(dPlus)
	);
	uhb_pin_sync syncMinus (
		.ref_clk(ref_clk),
		.srst(srst),
		.pinIn(dMinusIn),
		.level(dMinus)
	);

	// Live line status, registered so reads are stable
	wire line_idle_state_flag = lowSpeed ? (!dPlus && dMinus) : (dPlus && !dMinus);
	wire se0 = !dPlus && !dMinus;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lineIdleStateFlag <= 1'b0;
			lineSe0 <= 1'b0;
		end else begin
			lineIdleStateFlag <= line_idle_state_flag;
			lineSe0 <= se0;
		end
	end

	// APB decode: zero wait states, unmapped addresses answer with an error
	wire access = psel && penable;
	wire hitControl = paddr == uhb_pkg::ADDR_HOST_CONTROL;
	wire hitLine = paddr == uhb_pkg::ADDR_LINE_INPUT;
	wire mapped = hitControl || hitLine;
	wire writeControl = access && pwrite && hitControl;
	wire [7:0] statusByte = {lineIdleStateFlag, lineSe0, tokenInProgress, control[4:0]};
	wire [31:0] readControl = {24'h000000, statusByte};
	wire [31:0] readLine = {30'h0, dMinus, dPlus};
	wire [31:0] readMux = hitControl ? readControl : (hitLine ? readLine : 32'h00000000);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			control <= uhb_pkg::CONTROL_RESET;
		end else if (writeControl) begin
			// Status bits above bit 4 are not stored from the bus
			control <= pwdata[5:0] & uhb_pkg::CONTROL_WRITE_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= readMux;
		end
	end

	// Line controls held while software keeps the bits set; duration is software's job
	assign busResetDrive = control[uhb_pkg::BIT_BUS_RESET];
	assign resumeDrive = control[uhb_pkg::BIT_RESUME];
	assign hostRoleEnable = control[uhb_pkg::BIT_HOST_ENABLE];
	assign pullDownEnable = control[uhb_pkg::BIT_HOST_ENABLE];
	assign bufferPointerRewind = control[uhb_pkg::BIT_REWIND];
	wire frameEnable = control[uhb_pkg::BIT_FRAME_ENABLE] && hostRoleEnable;

	// Frame timer; restarts from zero on enable so the first marker is a full period away
	wire frameTick = frameCount == 32'(FRAME_PERIOD - 1);
	always_ff @(posedge ref_clk) begin
		if (srst || !frameEnable) begin
			frameCount <= 32'h00000000;
		end else if (frameTick) begin
			frameCount <= 32'h00000000;
		end else begin
			frameCount <= frameCount + 32'h00000001;
		end
	end

	// Token sequencer: frame marker has priority over a queued request
	wire tokenDone = tokenCount == 32'(TOKEN_CYCLES - 1);
	wire lineBlocked = busResetDrive || resumeDrive;
	always_comb begin
		next_state = state;
		case (state)
			uhb_pkg::ST_IDLE: begin
				if (frameTick && frameEnable && !lineBlocked) begin
					next_state = uhb_pkg::ST_SOF;
				end else if (tokenRequest && hostRoleEnable && !lineBlocked) begin
					next_state = uhb_pkg::ST_TOKEN;
				end
			end
			uhb_pkg::ST_SOF: begin
				if (tokenDone) begin
					next_state = uhb_pkg::ST_IDLE;
				end
			end
			uhb_pkg::ST_TOKEN: begin
				if (tokenDone) begin
					next_state = uhb_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = uhb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= uhb_pkg::ST_IDLE;
			tokenCount <= 32'h00000000;
			sofStart <= 1'b0;
		end else begin
			state <= next_state;
			sofStart <= (state == uhb_pkg::ST_IDLE) && (next_state == uhb_pkg::ST_SOF);
			if (state == uhb_pkg::ST_IDLE || tokenDone) begin
				tokenCount <= 32'h00000000;
			end else begin
				tokenCount <= tokenCount + 32'h00000001;
			end
		end
	end

	assign tokenInProgress = state != uhb_pkg::ST_IDLE;
endmodule : uhb_host_bus_control

// *** common/uhb_pkg.sv ***
/*
 * Package for the USB host bus control block: register map, field positions,
 * reset values and timing constants.
 * Assumes a 20 MHz ref_clk and an APB register port with 32-bit data.
 */
package uhb_pkg;
	localparam logic [11:0] ADDR_HOST_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_LINE_INPUT = 12'h004;
	localparam int BIT_IDLE_STATE = 7;
	localparam int BIT_SE0 = 6;
	localparam int BIT_TOKEN_BUSY = 5;
	localparam int BIT_BUS_RESET = 4;
	localparam int BIT_HOST_ENABLE = 3;
	localparam int BIT_RESUME = 2;
	localparam int BIT_REWIND = 1;
	localparam int BIT_FRAME_ENABLE = 0;
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic [5:0] CONTROL_WRITE_MASK = 6'h1f;
	localparam int CLOCK_HZ = 20000000;
	localparam int FRAME_TIME_US = 1000;
	localparam int FRAME_CYCLES = CLOCK_HZ / 1000000 * FRAME_TIME_US;
	localparam int BUS_RESET_TIME_MS = 50;
	localparam int RESUME_TIME_MS = 10;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SOF = 3'b010,
		ST_TOKEN = 3'b100
	} uhb_state_e;
endpackage : uhb_pkg

// *** core/uhb_pin_sync.sv ***
/*
 * Three-stage pin synchroniser; a change is taken when stages two and three agree.
 * Assumes the input is asynchronous to ref_clk.
 */
`timescale 1ns/1ns
module uhb_pin_sync (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage;
	wire agree = stage[1] == stage[2];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage <= 3'h0;
			level <= 1'b0;
		end else begin
			stage <= {stage[1:0], pinIn};
			if (agree) begin
				level <= stage[2];
			end
		end
	end
endmodule : uhb_pin_sync

// *** test/uhb_host_bus_control_checker.sv ***
/* Port checker for the host bus control block.
   Bound to the design top; uses its port names only. */
`timescale 1ns/1ns
module uhb_host_bus_control_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic tokenRequest,
	input wire logic busResetDrive,
	input wire logic resumeDrive,
	input wire logic pullDownEnable,
	input wire logic hostRoleEnable,
	input wire logic sofStart,
	input wire logic tokenInProgress
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic wr = psel && penable && pwrite && paddr == 12'h000;
	property p_pull; wr |=> pullDownEnable == $past(pwdata[3]); endproperty
	a_pull: assert property (p_pull) else $error("pull-down differs");
	property p_sofhost; sofStart |-> hostRoleEnable; endproperty
	a_sofhost: assert property (p_sofhost) else $error("frame mark without host");
	property p_host; wr |=> hostRoleEnable == $past(pwdata[3]); endproperty
	a_host: assert property (p_host) else $error("host bit lost");
	property p_rst; wr |=> busResetDrive == $past(pwdata[4]); endproperty
	a_rst: assert property (p_rst) else $error("bus reset bit lost");
	property p_res; wr |=> resumeDrive == $past(pwdata[2]); endproperty
	a_res: assert property (p_res) else $error("resume bit lost");
	property p_tok; tokenRequest && !tokenInProgress && hostRoleEnable && !busResetDrive
		&& !resumeDrive |=> tokenInProgress; endproperty
	a_tok: assert property (p_tok) else $error("token not started");
	property p_len; $rose(tokenInProgress) |-> tokenInProgress [*8]; endproperty
	a_len: assert property (p_len) else $error("token too short");
	property p_sof; sofStart |=> !sofStart [*8]; endproperty
	a_sof: assert property (p_sof) else $error("frame marks too close");
	property p_up; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits set");
endmodule : uhb_host_bus_control_checker
bind uhb_host_bus_control uhb_host_bus_control_checker uhb_host_bus_control_checker_i (.*);

// *** test/uhb_usb_function.sv ***
/* Far-side function model driving the D+ and D- receiver levels.
   Assumes the bench selects the line condition. */
`timescale 1ns/1ns
module uhb_usb_function (
	input wire logic [1:0] lineMode,
	output logic dPlus,
	output logic dMinus
);
	// 0 gives SE0 (both lines pulled low), 1 raises D+, 2 raises D-
	assign dPlus = lineMode == 2'h1;
	assign dMinus = lineMode == 2'h2;
endmodule : uhb_usb_function

// *** test/uhb_host_bus_control_tb_top.sv ***
/* Self-checking bench: APB register tasks, line and token scenarios.
   Assumes a short frame period so several frames fit the run. */
`timescale 1ns/1ns
module uhb_host_bus_control_tb_top;
	logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, e;
	logic dPlusIn, dMinusIn, lowSpeed, tokenRequest, busResetDrive, resumeDrive;
	logic pullDownEnable, hostRoleEnable, bufferPointerRewind, sofStart, tokenInProgress;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] lineMode;
	int n, cyc, numChecks, miscompares;
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
	uhb_host_bus_control #(.FRAME_PERIOD(50)) uhb_host_bus_control_i (.*);
	uhb_usb_function uhb_usb_function_i (.lineMode(lineMode), .dPlus(dPlusIn), .dMinus(dMinusIn));
	always #25 ref_clk = ~ref_clk;
	// Cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			giveVerdict();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	// Busy length of one requested token, zero when refused
	task automatic tok();
		tokenRequest <= 1'b1;
		@(posedge ref_clk);
		tokenRequest <= 1'b0;
		n = 0;
		@(negedge ref_clk);
		while (tokenInProgress === 1'b1 && n < 40) begin n++; @(negedge ref_clk); end
		@(posedge ref_clk);
	endtask : tok
	task automatic waitSof();
		n = 0;
		do begin @(negedge ref_clk); n++; end while (sofStart !== 1'b1 && n < 200);
		@(posedge ref_clk);
	endtask : waitSof
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : giveVerdict
	initial begin
		{ref_clk, psel, penable, pwrite, paddr, pwdata, lowSpeed, tokenRequest} = '0;
		srst = 1'b1; lineMode = 2'h1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		// Line flags need the synchroniser and status flop to settle before the first read
		repeat (8) @(posedge ref_clk);
		apb(0, 12'h000, 0); `CHK(r, 32'h80)
		apb(1, 12'h000, 32'hfffffffe); apb(0, 12'h000, 0); `CHK(r, 32'h9e)
		`CHK({busResetDrive, pullDownEnable, hostRoleEnable, resumeDrive, bufferPointerRewind}, 5'h1f)
		for (int i = 0; i < 6; i++) begin
			lowSpeed <= i[0]; lineMode <= i[2:1];
			repeat (8) @(posedge ref_clk);
			apb(0, 12'h000, 0);
			`CHK(r[7:6], {(i[0] ? i[2:1] == 2'h2 : i[2:1] == 2'h1), i[2:1] == 2'h0})
		end
		apb(0, 12'h004, 0); `CHK({e, r}, 33'h2)
		tok(); `CHK(n, 0)
		apb(1, 12'h000, 32'h08); tok(); `CHK(n, 16)
		`CHK({busResetDrive, pullDownEnable, resumeDrive, bufferPointerRewind}, 4'h4)
		apb(0, 12'h008, 0); `CHK({e, r}, 33'h100000000)
		apb(1, 12'h000, 32'h09); waitSof(); waitSof(); `CHK(n, 50)
		apb(1, 12'h000, 32'h08); waitSof(); `CHK(n, 200)
		giveVerdict();
	end
endmodule : uhb_host_bus_control_tb_top
